/* verilog/branch_compare_unit.sv */
// Combinational unit that forms compare flags and branch or skip
// conditions; its package sits in the control-flow file.
// Assumes operands and status flags are stable for the whole cycle.
`timescale 1ns/10ps

module compare_flags_unit import branch_skip_compare_pkg::*; (
	input  wire op_t        i_op,
	input  wire logic [7:0] i_rd,
	input  wire logic [7:0] i_rr,
	input  wire logic [7:0] i_imm,
	input  wire logic [7:0] i_flags,
	input  wire logic [2:0] i_bit_sel,
	input  wire logic [2:0] i_flag_sel,
	input  wire logic       i_io_bit,
	output logic [7:0]      o_flags,
	output logic            o_condition
);
	wire        use_imm   = (i_op == compare_immediate);
	wire        use_carry = (i_op == compare_with_carry);
	wire [7:0]  subtrahend = use_imm ? i_imm : i_rr;
	wire [8:0]  difference = {1'b0, i_rd} - {1'b0, subtrahend}
		- {8'h00, use_carry & i_flags[FLAG_CARRY]};
	wire [7:0]  result = difference[7:0];
	wire        borrow_half = (~i_rd[3] & subtrahend[3])
		| (subtrahend[3] & result[3]) | (result[3] & ~i_rd[3]);
	wire        overflow = (i_rd[7] & ~subtrahend[7] & ~result[7])
		| (~i_rd[7] & subtrahend[7] & result[7]);
	wire        zero_raw = (result == 8'h00);
	// Carry compare keeps zero only if it was already set
	wire        zero = use_carry ? (zero_raw & i_flags[FLAG_ZERO]) : zero_raw;
	wire        sign_test = i_flags[FLAG_NEGATIVE] ^ i_flags[FLAG_OVERFLOW];

	always_comb begin
		o_flags = i_flags;
		o_flags[FLAG_CARRY] = difference[8];
		o_flags[FLAG_ZERO] = zero;
		o_flags[FLAG_NEGATIVE] = result[7];
		o_flags[FLAG_OVERFLOW] = overflow;
		o_flags[FLAG_SIGN] = result[7] ^ overflow;
		o_flags[FLAG_HALF] = borrow_half;
	end

	always_comb begin
		case (i_op)
			compare_skip_equal:    o_condition = (i_rd == i_rr);
			skip_reg_bit_clear:    o_condition = ~i_rr[i_bit_sel];
			skip_reg_bit_set:      o_condition = i_rr[i_bit_sel];
			skip_io_bit_clear:     o_condition = ~i_io_bit;
			skip_io_bit_set:       o_condition = i_io_bit;
			branch_flag_set:       o_condition = i_flags[i_flag_sel];
			branch_flag_clear:     o_condition = ~i_flags[i_flag_sel];
			branch_equal:          o_condition = i_flags[FLAG_ZERO];
			branch_not_equal:      o_condition = ~i_flags[FLAG_ZERO];
			branch_carry_set,
			branch_lower:          o_condition = i_flags[FLAG_CARRY];
			branch_carry_clear,
			branch_same_higher:    o_condition = ~i_flags[FLAG_CARRY];
			branch_minus:          o_condition = i_flags[FLAG_NEGATIVE];
			branch_plus:           o_condition = ~i_flags[FLAG_NEGATIVE];
			branch_greater_equal:  o_condition = ~sign_test;
			branch_less_than:      o_condition = sign_test;
			branch_half_carry_set: o_condition = i_flags[FLAG_HALF];
			branch_half_carry_clr: o_condition = ~i_flags[FLAG_HALF];
			branch_tbit_set:       o_condition = i_flags[FLAG_TBIT];
			default:               o_condition = 1'b0;
		endcase
	end
endmodule

/* verilog/branch_skip_compare_control.sv */
// Control-flow execution for the 8-bit core: jumps, calls, returns,
// compares, skips and flag branches, with per-instruction cycle counts.
// The package shared with the compare unit leads the file.
// Assumes the decoder presents one instruction with valid, the fetch
// stage honours busy and flush, and the stack shows its top word.
//
// Overview of operation
// - Indirect jump loads Z, two cycles.
// - Relative call pushes, jumps PC+k+1, three cycles.
// - Indirect call pushes, jumps to Z, three cycles.
// - Equal registers skip next; one to three cycles.
// - Compares set Z N V C H, one cycle.
// - Register bit clear skips next instruction.
// - Register bit set skips next instruction.
// - I/O bit clear or set skips next.
// - Branch when chosen status bit is one.
// - Branch when chosen status bit is zero.
// - Equal on Z one, not-equal on zero.
// - Carry set/lower on C one, else zero.
// - Minus on N one, plus on zero.
// - Signed greater-or-equal when N xor V zero.
// - Signed less-than when N xor V one.
// - Half-carry branches test H flag.
// - T-bit branches test T flag.
// - Overflow branches test V flag.
// - Skip adds two or three words.
`timescale 1ns/10ps
package branch_skip_compare_pkg;
	localparam int PC_WIDTH = 16;
	localparam int OFFSET_WIDTH = 12;
	// Status register bit positions
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_ZERO = 1;
	localparam int FLAG_NEGATIVE = 2;
	localparam int FLAG_OVERFLOW = 3;
	localparam int FLAG_SIGN = 4;
	localparam int FLAG_HALF = 5;
	localparam int FLAG_TBIT = 6;
	localparam int FLAG_INTERRUPT = 7;
	// Cycle counts per instruction
	localparam logic [2:0] CYCLES_INDIRECT_JUMP = 3'h2;
	localparam logic [2:0] CYCLES_DIRECT_JUMP = 3'h3;
	localparam logic [2:0] CYCLES_RELATIVE_JUMP = 3'h2;
	localparam logic [2:0] CYCLES_RELATIVE_CALL = 3'h3;
	localparam logic [2:0] CYCLES_INDIRECT_CALL = 3'h3;
	localparam logic [2:0] CYCLES_DIRECT_CALL = 3'h4;
	localparam logic [2:0] CYCLES_RETURN = 3'h4;
	localparam logic [2:0] CYCLES_SINGLE = 3'h1;
	localparam logic [2:0] CYCLES_BRANCH_TAKEN = 3'h2;
	localparam logic [2:0] CYCLES_SKIP_SHORT = 3'h2;
	localparam logic [2:0] CYCLES_SKIP_LONG = 3'h3;
	// Program counter steps
	localparam logic [15:0] PC_STEP_ONE = 16'h0001;
	localparam logic [15:0] PC_STEP_TWO = 16'h0002;
	localparam logic [15:0] PC_STEP_SKIP_SHORT = 16'h0002;
	localparam logic [15:0] PC_STEP_SKIP_LONG = 16'h0003;
	// Reset values
	localparam logic [15:0] RESET_PC = 16'h0000;
	localparam logic [7:0] RESET_FLAGS = 8'h00;
	localparam logic [2:0] RESET_COUNT = 3'h0;

	typedef enum logic [4:0] {
		no_operation          = 5'h00,
		indirect_jump         = 5'h01,
		direct_jump           = 5'h02,
		relative_jump         = 5'h03,
		relative_call         = 5'h04,
		indirect_call         = 5'h05,
		direct_call           = 5'h06,
		subroutine_return     = 5'h07,
		interrupt_return      = 5'h08,
		compare_skip_equal    = 5'h09,
		compare_regs          = 5'h0a,
		compare_with_carry    = 5'h0b,
		compare_immediate     = 5'h0c,
		skip_reg_bit_clear    = 5'h0d,
		skip_reg_bit_set      = 5'h0e,
		skip_io_bit_clear     = 5'h0f,
		skip_io_bit_set       = 5'h10,
		branch_flag_set       = 5'h11,
		branch_flag_clear     = 5'h12,
		branch_equal          = 5'h13,
		branch_not_equal      = 5'h14,
		branch_carry_set      = 5'h15,
		branch_carry_clear    = 5'h16,
		branch_same_higher    = 5'h17,
		branch_lower          = 5'h18,
		branch_minus          = 5'h19,
		branch_plus           = 5'h1a,
		branch_greater_equal  = 5'h1b,
		branch_less_than      = 5'h1c,
		branch_half_carry_set = 5'h1d,
		branch_half_carry_clr = 5'h1e,
		branch_tbit_set       = 5'h1f
	} op_t;

	// Opcode space is full; cleared T and overflow branches use select pins
	typedef struct packed {
		op_t         op;
		logic [7:0]  rd;
		logic [7:0]  rr;
		logic [7:0]  imm;
		logic [2:0]  bit_sel;
		logic [2:0]  flag_sel;
		logic [11:0] offset;
		logic        next_two_word;
		logic [15:0] second_word;
	} instr_t;

	typedef struct packed {
		logic        load;
		logic [15:0] target;
		logic        push;
		logic [15:0] push_data;
		logic        pop;
		logic        flush;
	} flow_t;
endpackage

module branch_skip_compare_control import branch_skip_compare_pkg::*; (
	input  wire logic        i_clock,
	input  wire logic        i_rst_b,
	input  wire logic        i_clock_en,
	input  wire logic        i_instr_valid,
	input  wire instr_t      i_instr,
	input  wire logic [15:0] i_pc,
	input  wire logic [15:0] i_z_pointer,
	input  wire logic [15:0] i_stack_top,
	input  wire logic [7:0]  i_flags,
	input  wire logic        i_io_bit,
	input  wire logic        i_tbit_clear_sel,
	input  wire logic        i_overflow_sel,
	output logic             o_busy,
	output logic             o_done,
	output flow_t            o_flow,
	output logic             o_flags_we,
	output logic [7:0]       o_flags
);
	typedef enum logic [1:0] {
		idle  = 2'b01,
		stall = 2'b10
	} state_t;

	state_t      state;
	state_t      next_state;
	logic [2:0]  remaining;
	logic [2:0]  next_remaining;
	flow_t       next_flow;
	logic        next_flags_we;
	logic [7:0]  next_flags;
	logic [2:0]  cycles;
	logic        condition;
	logic [7:0]  compare_flags;

	// Sign extension of the relative offset
	function automatic logic [15:0] extend(input logic [11:0] value);
		extend = {{4{value[11]}}, value};
	endfunction

	// Instruction classes used by several decisions
	function automatic logic is_skip(input op_t op);
		is_skip = (op == compare_skip_equal) || (op == skip_reg_bit_clear)
			|| (op == skip_reg_bit_set) || (op == skip_io_bit_clear)
			|| (op == skip_io_bit_set);
	endfunction

	function automatic logic is_branch(input op_t op);
		is_branch = (op >= branch_flag_set) && (op <= branch_tbit_set);
	endfunction

	function automatic logic is_compare(input op_t op);
		is_compare = (op == compare_regs) || (op == compare_with_carry)
			|| (op == compare_immediate);
	endfunction

	wire        accept = i_instr_valid && (state == idle) && i_clock_en;
	wire op_t   op = i_instr.op;
	wire [15:0] pc_next = i_pc + PC_STEP_ONE;
	wire [15:0] relative_target = i_pc + extend(i_instr.offset)
		+ PC_STEP_ONE;
	wire [15:0] skip_target = i_pc + (i_instr.next_two_word
		? PC_STEP_SKIP_LONG : PC_STEP_SKIP_SHORT);
	// Cleared T-bit and overflow branches ride on the flag-set codes
	wire        tbit_inverted = (op == branch_tbit_set) && i_tbit_clear_sel;
	wire        overflow_branch = (op == branch_flag_set) && i_overflow_sel;
	wire [2:0]  flag_select = overflow_branch
		? FLAG_OVERFLOW[2:0] : i_instr.flag_sel;
	wire        raw_condition;
	wire        overflow_condition = i_flags[FLAG_OVERFLOW]
		^ i_tbit_clear_sel;
	wire        tbit_condition = ~i_flags[FLAG_TBIT];

	assign condition = overflow_branch ? overflow_condition
		: (tbit_inverted ? tbit_condition : raw_condition);

	compare_flags_unit flags_unit (
		.i_op        (op),
		.i_rd        (i_instr.rd),
		.i_rr        (i_instr.rr),
		.i_imm       (i_instr.imm),
		.i_flags     (i_flags),
		.i_bit_sel   (i_instr.bit_sel),
		.i_flag_sel  (flag_select),
		.i_io_bit    (i_io_bit),
		.o_flags     (compare_flags),
		.o_condition (raw_condition)
	);

	// Flow change and cycle count of the accepted instruction
	always_comb begin
		next_flow = '0;
		next_flags_we = 1'b0;
		next_flags = i_flags;
		cycles = CYCLES_SINGLE;
		case (op)
			indirect_jump: begin
				next_flow.load = 1'b1;
				next_flow.target = i_z_pointer;
				cycles = CYCLES_INDIRECT_JUMP;
			end
			direct_jump: begin
				next_flow.load = 1'b1;
				next_flow.target = i_instr.second_word;
				cycles = CYCLES_DIRECT_JUMP;
			end
			relative_jump: begin
				next_flow.load = 1'b1;
				next_flow.target = relative_target;
				cycles = CYCLES_RELATIVE_JUMP;
			end
			relative_call: begin
				next_flow.load = 1'b1;
				next_flow.target = relative_target;
				next_flow.push = 1'b1;
				next_flow.push_data = pc_next;
				cycles = CYCLES_RELATIVE_CALL;
			end
			indirect_call: begin
				next_flow.load = 1'b1;
				next_flow.target = i_z_pointer;
				next_flow.push = 1'b1;
				next_flow.push_data = pc_next;
				cycles = CYCLES_INDIRECT_CALL;
			end
			direct_call: begin
				next_flow.load = 1'b1;
				next_flow.target = i_instr.second_word;
				next_flow.push = 1'b1;
				next_flow.push_data = i_pc + PC_STEP_TWO;
				cycles = CYCLES_DIRECT_CALL;
			end
			subroutine_return,
			interrupt_return: begin
				next_flow.load = 1'b1;
				next_flow.target = i_stack_top;
				next_flow.pop = 1'b1;
				cycles = CYCLES_RETURN;
				if (op == interrupt_return) begin
					next_flags_we = 1'b1;
					next_flags[FLAG_INTERRUPT] = 1'b1;
				end
			end
			default: begin
				if (is_compare(op)) begin
					next_flags_we = 1'b1;
					next_flags = compare_flags;
				end else if (is_skip(op) && condition) begin
					next_flow.load = 1'b1;
					next_flow.target = skip_target;
					cycles = i_instr.next_two_word
						? CYCLES_SKIP_LONG : CYCLES_SKIP_SHORT;
				end else if (is_branch(op) && condition) begin
					next_flow.load = 1'b1;
					next_flow.target = relative_target;
					cycles = CYCLES_BRANCH_TAKEN;
				end
			end
		endcase
		// Any taken change of flow drops the prefetched word
		next_flow.flush = next_flow.load;
	end

	// Stall for the extra cycles of the instruction
	always_comb begin
		next_state = state;
		next_remaining = remaining;
		case (state)
			idle: begin
				if (accept && (cycles > CYCLES_SINGLE)) begin
					next_state = stall;
					next_remaining = cycles - CYCLES_SINGLE;
				end
			end
			stall: begin
				next_remaining = remaining - 3'h1;
				if (remaining == 3'h1) begin
					next_state = idle;
				end
			end
			default: begin
				next_state = idle;
				next_remaining = RESET_COUNT;
			end
		endcase
	end

	assign o_busy = (state != idle);
	assign o_done = (accept && (cycles == CYCLES_SINGLE))
		|| ((state == stall) && (remaining == 3'h1));

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state <= idle;
			remaining <= RESET_COUNT;
		end else if (i_clock_en) begin
			state <= next_state;
			remaining <= next_remaining;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_flow <= '0;
			o_flags_we <= 1'b0;
			o_flags <= RESET_FLAGS;
		end else if (i_clock_en) begin
			o_flow <= accept ? next_flow : '0;
			o_flags_we <= accept && next_flags_we;
			if (accept && next_flags_we) begin
				o_flags <= next_flags;
			end
		end
	end
endmodule

/* verif/branch_skip_compare_control_properties.sv */
// Checker for the control-flow block, on its ports only.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/10ps
module bscc_checker import branch_skip_compare_pkg::*; (
	input  wire logic        i_clock,
	input  wire logic        i_rst_b,
	input  wire logic        i_clock_en,
	input  wire logic        i_instr_valid,
	input  wire instr_t      i_instr,
	input  wire logic [15:0] i_pc,
	input  wire logic [15:0] i_z_pointer,
	input  wire logic [7:0]  i_flags,
	input  wire logic        i_io_bit,
	input  wire logic        o_busy,
	input  wire logic        o_done,
	input  wire flow_t       o_flow,
	input  wire logic        o_flags_we
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	wire  acc = i_instr_valid && !o_busy && i_clock_en;
	wire  op_t op = i_instr.op;
	wire  [15:0] rel = i_pc + {{4{i_instr.offset[11]}}, i_instr.offset}
		+ 16'h0001;
	sequence s_two;
		o_busy ##1 !o_busy;
	endsequence
	sequence s_three;
		o_busy ##1 o_busy ##1 !o_busy;
	endsequence
	sequence s_four;
		o_busy ##1 o_busy ##1 o_busy ##1 !o_busy;
	endsequence
	property p_ret;
		acc && op inside {subroutine_return, interrupt_return} |=>
			(o_flow.pop && o_flow.load) ##0 s_four;
	endproperty
	property p_indirect_jump;
		acc && op == indirect_jump |=> (o_flow.load && !o_flags_we
			&& o_flow.target == $past(i_z_pointer)) ##0 s_two;
	endproperty
	property p_relative_call;
		acc && op == relative_call |=> (o_flow.push && o_flow.target
			== $past(rel) && o_flow.push_data == $past(i_pc) + 16'h0001)
			##0 s_three;
	endproperty
	property p_indirect_call;
		acc && op == indirect_call |=> (o_flow.push && !o_flags_we
			&& o_flow.target == $past(i_z_pointer)) ##0 s_three;
	endproperty
	property p_cmp;
		acc && op inside {[compare_regs:compare_immediate]} |-> o_done
			##1 o_flags_we && !o_flow.load && !o_busy;
	endproperty
	property p_eq;
		acc && op == branch_equal |=>
			o_flow.load == $past(i_flags[FLAG_ZERO]);
	endproperty
	property p_lt;
		acc && op == branch_less_than |=> o_flow.load ==
			($past(i_flags[FLAG_NEGATIVE]) ^ $past(i_flags[FLAG_OVERFLOW]));
	endproperty
	property p_skip;
		acc && op == skip_io_bit_set && i_io_bit |=> o_flow.load
			&& o_flow.target == $past(i_pc)
			+ ($past(i_instr.next_two_word) ? 16'h0003 : 16'h0002);
	endproperty
	property p_carry;
		acc && op == branch_carry_set && i_flags[FLAG_CARRY] |=>
			(o_flow.load && o_flow.target == $past(rel)) ##0 s_two;
	endproperty
	property p_flush;
		o_flow.load |-> o_flow.flush;
	endproperty
	a_indirect_jump: assert property (p_indirect_jump) else $error("indirect_jump bad");
	a_relative_call: assert property (p_relative_call) else $error("relative_call bad");
	a_indirect_call: assert property (p_indirect_call) else $error("indirect_call bad");
	a_cmp: assert property (p_cmp) else $error("compare bad");
	a_eq: assert property (p_eq) else $error("equal bad");
	a_lt: assert property (p_lt) else $error("less bad");
	a_skip: assert property (p_skip) else $error("skip bad");
	a_carry: assert property (p_carry) else $error("carry bad");
	a_flush: assert property (p_flush) else $error("flush bad");
	a_ret: assert property (p_ret) else $error("return bad");
endmodule
bind branch_skip_compare_control bscc_checker chk (.i_clock(i_clock),
	.i_rst_b(i_rst_b), .i_clock_en(i_clock_en),
	.i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_pc(i_pc),
	.i_z_pointer(i_z_pointer), .i_flags(i_flags), .i_io_bit(i_io_bit),
	.o_busy(o_busy), .o_done(o_done), .o_flow(o_flow),
	.o_flags_we(o_flags_we));

/* verif/fetch_stack_model.sv */
// Far-side model: program counter and top of stack.
// Assumes flow requests are one-cycle pulses.
`timescale 1ns/10ps
module fetch_stack_model import branch_skip_compare_pkg::*; (
	input  wire logic   i_clock,
	input  wire logic   i_rst_b,
	input  wire flow_t  i_flow,
	output logic [15:0] o_pc,
	output logic [15:0] o_stack_top
);
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pc <= 16'h0000;
			o_stack_top <= 16'h0000;
		end else begin
			if (i_flow.load) o_pc <= i_flow.target;
			if (i_flow.push) o_stack_top <= i_flow.push_data;
		end
	end
endmodule

/* verif/branch_skip_compare_control_bench.sv */
// Self-checking bench for the control-flow block.
// Assumes the far-side model stands in for fetch and stack.
`timescale 1ns/10ps
module branch_skip_compare_control_bench import branch_skip_compare_pkg::*;;
	logic        clock = 0, rst_b = 0, valid = 0, io = 0, tc = 0, ov = 0;
	logic        ce = 1;
	instr_t      ins = '0;
	logic [15:0] pc = 0, z = 0, mpc, mst, e_tgt;
	logic [7:0]  fl_in = 0, fl_out;
	logic        busy, done, fwe;
	flow_t       flow;
	op_t         o;
	int          err_count = 0, total_checks = 0, cyc = 0, n;
	always #5 clock = ~clock;
	branch_skip_compare_control DUT (.i_clock(clock), .i_rst_b(rst_b),
		.i_clock_en(ce), .i_instr_valid(valid), .i_instr(ins),
		.i_pc(pc), .i_z_pointer(z), .i_stack_top(mst), .i_flags(fl_in),
		.i_io_bit(io), .i_tbit_clear_sel(tc), .i_overflow_sel(ov),
		.o_busy(busy), .o_done(done), .o_flow(flow),
		.o_flags_we(fwe), .o_flags(fl_out));
	fetch_stack_model model (.i_clock(clock), .i_rst_b(rst_b),
		.i_flow(flow), .o_pc(mpc), .o_stack_top(mst));
	task give_verdict;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc > 20000) begin
			err_count++;
			give_verdict;
		end
	end
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	function automatic logic taken(instr_t x, logic [7:0] f);
		case (x.op)
			compare_skip_equal: return x.rd == x.rr;
			skip_reg_bit_clear: return !x.rr[x.bit_sel];
			skip_reg_bit_set: return x.rr[x.bit_sel];
			skip_io_bit_clear: return !io;
			skip_io_bit_set: return io;
			branch_flag_set: return ov ? f[3] ^ tc : f[x.flag_sel];
			branch_flag_clear: return !f[x.flag_sel];
			branch_equal: return f[1];
			branch_not_equal: return !f[1];
			branch_carry_set, branch_lower: return f[0];
			branch_carry_clear, branch_same_higher: return !f[0];
			branch_minus: return f[2];
			branch_plus: return !f[2];
			branch_greater_equal: return !(f[2] ^ f[3]);
			branch_less_than: return f[2] ^ f[3];
			branch_half_carry_set: return f[5];
			branch_half_carry_clr: return !f[5];
			branch_tbit_set: return f[6] ^ tc;
			default: return 1'b1;
		endcase
	endfunction
	// Expected H S V N Z C of a compare
	function automatic logic [5:0] cmpf(instr_t x, logic [7:0] f);
		logic [8:0] d;
		logic [7:0] b;
		logic       v;
		b = x.op == compare_immediate ? x.imm : x.rr;
		d = {1'b0, x.rd} - {1'b0, b} - (x.op == compare_with_carry && f[0]);
		v = x.rd[7] & ~b[7] & ~d[7] | ~x.rd[7] & b[7] & d[7];
		return {~x.rd[3] & b[3] | b[3] & d[3] | d[3] & ~x.rd[3],
			d[7] ^ v, v, d[7],
			d[7:0] == 0 && (x.op != compare_with_carry || f[1]), d[8]};
	endfunction
	task automatic run(op_t op, logic corner);
		logic tk, cl, sk, cp, rt, dr;
		logic [15:0] ep;
		int   en;
		@(posedge clock);
		#1;
		ins = {$urandom, $urandom};
		ins.op = op;
		pc = 16'($urandom);
		z = 16'($urandom);
		fl_in = 8'($urandom);
		io = 1'($urandom);
		tc = 1'($urandom);
		ov = op == branch_flag_set && 1'($urandom);
		if (corner) begin
			ins.offset = 12'h800;
			ins.rr = ins.rd;
			ins.next_two_word = 1'b1;
			pc = 16'hffff;
			io = 1'b1;
		end
		valid = 1;
		sk = op inside {compare_skip_equal, [skip_reg_bit_clear:skip_io_bit_set]};
		cp = op inside {[compare_regs:compare_immediate]};
		cl = op inside {relative_call, indirect_call, direct_call};
		rt = op inside {subroutine_return, interrupt_return};
		dr = op inside {direct_jump, direct_call};
		ep = pc + (op == direct_call ? 16'h0002 : 16'h0001);
		tk = taken(ins, fl_in) && !cp;
		e_tgt = op inside {indirect_jump, indirect_call} ? z
			: dr ? ins.second_word : rt ? mst : sk ? pc
			+ (ins.next_two_word ? 16'h0003 : 16'h0002)
			: pc + {{4{ins.offset[11]}}, ins.offset} + 16'h0001;
		en = !tk ? 1 : sk ? (ins.next_two_word ? 3 : 2)
			: (rt || op == direct_call) ? 4
			: (cl || op == direct_jump) ? 3 : 2;
		@(posedge clock);
		#1;
		valid = 0;
		chk("load", 16'(tk), 16'(flow.load));
		if (tk) chk("target", e_tgt, flow.target);
		chk("push", 16'(cl), 16'(flow.push));
		if (cl) chk("push data", ep, flow.push_data);
		chk("pop", 16'(rt), 16'(flow.pop));
		chk("flags we", 16'(cp || op == interrupt_return), 16'(fwe));
		if (cp) chk("flags", 16'({fl_in[7:6], cmpf(ins, fl_in)}), 16'(fl_out));
		if (op == interrupt_return) chk("ie", 16'(fl_in | 8'h80), 16'(fl_out));
		n = 1;
		while (busy && n < 9) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk("cycles", 16'(en), 16'(n));
		if (tk) chk("model pc", e_tgt, mpc);
		$display("test %s ends", op.name());
	endtask
	initial begin
		void'($urandom(57611));
		repeat (8) @(posedge clock);
		#1;
		rst_b = 1;
		for (int i = 1; i < 32; i++)
			run(op_t'(i), 1'b1);
		repeat (300) begin
			o = op_t'(5'($urandom_range(31, 1)));
			run(o, 1'b0);
		end
		@(posedge clock);
		#1;
		ce = 0;
		ins.op = indirect_jump;
		valid = 1;
		repeat (2) @(posedge clock);
		#1;
		chk("frozen load", 16'h0000, 16'(flow.load));
		chk("frozen busy", 16'h0000, 16'(busy));
		ce = 1;
		valid = 0;
		$display("test clock enable ends");
		@(posedge clock);
		#1;
		ins.op = relative_call;
		valid = 1;
		@(posedge clock);
		#1;
		valid = 0;
		rst_b = 0;
		#1;
		chk("busy in reset", 16'h0000, 16'(busy));
		chk("load in reset", 16'h0000, 16'(flow.load));
		@(posedge clock);
		#1;
		rst_b = 1;
		$display("test reset ends");
		run(branch_equal, 1'b0);
		give_verdict;
	end
endmodule
